// ==== fsc_bank.sv ====
// What this block does
// - Over-temperature fault latches boost bit 15 high.
// - Bit 15 and the pin clear only when bits 15 and 14 are written 1 together.
// - Bit 13 latches resistor-to-ground short; writing 13 and 12 together clears it.
// - Bit 11 latches missing string-config resistor; writing 11 and 10 clears it.
// - Bit 9 latches missing mode resistor; writing 9 and 8 clears it.
// - Bit 7 latches missing frequency resistor; writing 7 and 6 clears it.
// - Bit 5 latches boost over-current; writing 5 and 4 clears it.
// - Bit 3 latches boost high over-voltage; writing 3 and 2 clears it.
// - Bit 1 latches boost low over-voltage; writing 1 and 0 clears it.
// - LED bit 14 latches bus timeout; writing 14 and 13 clears it.
// - LED bit 12 latches bad string setup; writing 12 and 11 clears it.
// - LED bit 10 latches ground short, internal short or open string; writing 10 and 9 clears it.
// - LED bit 8 reads ground short state, read only.
// - LED bit 7 internal short, cleared with the combined flag.
// - LED bit 6 open string, cleared with the combined flag.
// - LED bits 5..0 read channel 6..1 fault state.
// - LED bit 15 is plain storage, reset zero.
//
// The implementer's own choice: register access over APB.
module fsc_bank #(
	parameter int ADDR_W = 8
) (
	input  wire logic                               ref_clk,
	input  wire logic                               reset,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [ADDR_W-1:0]                  paddr,
	input  wire logic [31:0]                        pwdata,
	input  wire logic [3:0]                         pstrb,
	output logic      [31:0]                        prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic [fsc_pkg::BOOST_FLAGS-1:0]    boost_fault_in,
	input  wire logic                               bus_timeout_in,
	input  wire logic                               bad_string_in,
	input  wire logic                               ground_short_in,
	input  wire logic                               internal_short_in,
	input  wire logic                               open_string_in,
	input  wire logic [fsc_pkg::CHANS-1:0]          chan_fault_in,
	output logic                                    fault_pin,
	output logic                                    irq
);
	import fsc_pkg::*;

	localparam int SYNC_W = BOOST_FLAGS + 5 + CHANS;

	generate
		if (ADDR_W < MIN_ADDR_W) begin : g_chk
			$error("fsc_bank address too narrow for the register map");
		end
	endgenerate

	// ==========================================================
	// Input synchronisation
	logic [SYNC_W-1:0]       raw_in;
	logic [SYNC_W-1:0]       sync_in;
	logic [BOOST_FLAGS-1:0]  boost_s;
	logic                    timeout_s;
	logic                    badstr_s;
	logic                    gnd_s;
	logic                    short_s;
	logic                    open_s;
	logic [CHANS-1:0]        chan_s;

	assign raw_in = {chan_fault_in, open_string_in, internal_short_in, ground_short_in,
		bad_string_in, bus_timeout_in, boost_fault_in};

	fsc_sync #(
		.W(SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.reset  (reset),
		.d      (raw_in),
		.q      (sync_in)
	);

	assign boost_s   = sync_in[BOOST_FLAGS-1:0];
	assign timeout_s = sync_in[BOOST_FLAGS];
	assign badstr_s  = sync_in[BOOST_FLAGS+1];
	assign gnd_s     = sync_in[BOOST_FLAGS+2];
	assign short_s   = sync_in[BOOST_FLAGS+3];
	assign open_s    = sync_in[BOOST_FLAGS+4];
	assign chan_s    = sync_in[SYNC_W-1:BOOST_FLAGS+5];

	// ==========================================================
	// Bus decode
	logic             wr_en;
	logic             setup;
	logic             sel_boost;
	logic             sel_led;
	logic             sel_stat;
	logic             sel_mask;
	logic [REG_W-1:0] wmask;
	logic [REG_W-1:0] wdat;

	function automatic logic pair_hit(input logic [REG_W-1:0] d, input int s);
		pair_hit = d[s] & d[s-1];
	endfunction

	assign wr_en     = psel & penable & pwrite;
	assign setup     = psel & ~penable;
	assign sel_boost = (paddr == ADDR_W'(BOOST_ADDR));
	assign sel_led   = (paddr == ADDR_W'(LED_ADDR));
	assign sel_stat  = (paddr == ADDR_W'(IRQ_STAT_ADDR));
	assign sel_mask  = (paddr == ADDR_W'(IRQ_MASK_ADDR));
	assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wdat      = pwdata[REG_W-1:0] & wmask;
	// Zero wait states: every access completes in its first access cycle
	assign pready    = 1'b1;

	// ==========================================================
	// Boost fault flags and their clear bits
	logic [BOOST_FLAGS-1:0] boost_q;
	logic [BOOST_FLAGS-1:0] boost_clr;
	logic [BOOST_FLAGS-1:0] boost_ctl_reg;

	always_comb begin
		for (int k = 0; k < BOOST_FLAGS; k++) begin
			boost_clr[k] = wr_en & sel_boost & pair_hit(wdat, 2 * k + 1);
		end
	end

	fsc_flags #(
		.N(BOOST_FLAGS)
	) u_boost_flags (
		.ref_clk(ref_clk),
		.reset  (reset),
		.set    (boost_s),
		.clr    (boost_clr),
		.q      (boost_q)
	);

	// Clear bits read back what was last written
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			boost_ctl_reg <= '0;
		end else if (wr_en && sel_boost) begin
			for (int k = 0; k < BOOST_FLAGS; k++) begin
				if (wmask[2 * k]) begin
					boost_ctl_reg[k] <= pwdata[2 * k];
				end
			end
		end
	end

	// ==========================================================
	// LED fault flags: [0] combined, [1] bad string, [2] timeout
	logic [LED_FLAGS-1:0]    led_set;
	logic [LED_FLAGS-1:0]    led_clr;
	logic [LED_FLAGS-1:0]    led_q;
	logic [DETAIL_FLAGS-1:0] detail_q;
	logic                    short_q;
	logic                    open_q;
	logic [LED_CTL_BITS-1:0] led_ctl_reg;

	assign led_set = {timeout_s, badstr_s, gnd_s | short_s | open_s};

	always_comb begin
		for (int k = 0; k < LED_FLAGS; k++) begin
			led_clr[k] = wr_en & sel_led & pair_hit(wdat, LED_COMB_BIT + 2 * k);
		end
	end

	fsc_flags #(
		.N(LED_FLAGS)
	) u_led_flags (
		.ref_clk(ref_clk),
		.reset  (reset),
		.set    (led_set),
		.clr    (led_clr),
		.q      (led_q)
	);

	// Detail flags share the combined flag's clear
	fsc_flags #(
		.N(DETAIL_FLAGS)
	) u_detail_flags (
		.ref_clk(ref_clk),
		.reset  (reset),
		.set    ({short_s, open_s}),
		.clr    ({DETAIL_FLAGS{led_clr[0]}}),
		.q      (detail_q)
	);

	assign short_q = detail_q[1];
	assign open_q  = detail_q[0];

	// Bits 15, 13, 11, 9 as plain storage
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			led_ctl_reg <= '0;
		end else if (wr_en && sel_led && pstrb[1]) begin
			for (int k = 0; k < LED_CTL_BITS; k++) begin
				led_ctl_reg[k] <= pwdata[LED_COMB_BIT - 1 + 2 * k];
			end
		end
	end

	// ==========================================================
	// Fault pin and interrupt
	logic [BOOST_FLAGS-1+LED_FLAGS-1:0] pin_src;
	logic                               fault_pin_reg;
	logic [IRQ_BITS-1:0]                irq_evt;
	logic [IRQ_BITS-1:0]                irq_w1c;
	logic [IRQ_BITS-1:0]                irq_status_reg;
	logic [IRQ_BITS-1:0]                irq_mask_reg;

	// Low over-voltage flag leaves the pin alone
	assign pin_src = {boost_q[BOOST_FLAGS-1:1], led_q};

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			fault_pin_reg <= 1'b0;
		end else begin
			fault_pin_reg <= |pin_src;
		end
	end

	assign fault_pin = fault_pin_reg;

	always_comb begin
		irq_evt                = '0;
		irq_evt[IRQ_BOOST_BIT] = |(boost_s & ~boost_q);
		irq_evt[IRQ_LED_BIT]   = |(led_set & ~led_q);
		irq_w1c                = (wr_en && sel_stat) ? wdat[IRQ_BITS-1:0] : '0;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= irq_evt | (irq_status_reg & ~irq_w1c);
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (wr_en && sel_mask && pstrb[0]) begin
			irq_mask_reg <= pwdata[IRQ_BITS-1:0];
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// Read data, captured in the setup cycle
	logic [REG_W-1:0] boost_rd;
	logic [REG_W-1:0] led_rd;
	logic [31:0]      prdata_next;
	logic             pslverr_next;
	logic [31:0]      prdata_reg;
	logic             pslverr_reg;

	always_comb begin
		for (int k = 0; k < BOOST_FLAGS; k++) begin
			boost_rd[2 * k + 1] = boost_q[k];
			boost_rd[2 * k]     = boost_ctl_reg[k];
		end
	end

	assign led_rd = {led_ctl_reg[3], led_q[2], led_ctl_reg[2], led_q[1], led_ctl_reg[1],
		led_q[0], led_ctl_reg[0], gnd_s, short_q, open_q, chan_s};

	always_comb begin
		prdata_next  = '0;
		pslverr_next = 1'b0;
		if (sel_boost) begin
			prdata_next[REG_W-1:0] = boost_rd;
		end else if (sel_led) begin
			prdata_next[REG_W-1:0] = led_rd;
		end else if (sel_stat) begin
			prdata_next[IRQ_BITS-1:0] = irq_status_reg;
		end else if (sel_mask) begin
			prdata_next[IRQ_BITS-1:0] = irq_mask_reg;
		end else begin
			pslverr_next = 1'b1;
		end
		if (pwrite) begin
			prdata_next = '0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg  <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// ==========================================================
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence pair_wr(logic sel, int s);
		wr_en && sel && wdat[s] && wdat[s-1];
	endsequence

	sequence led_rd_seq;
		psel && !penable && !pwrite && sel_led ##1 psel && penable;
	endsequence

	overtemp_set_a: assert property (boost_s[BOOST_FLAGS-1] |=> boost_q[BOOST_FLAGS-1])
		else $error("overtemp flag not latched");

	genvar g;
	generate
		for (g = 0; g < BOOST_FLAGS; g++) begin : g_boost_chk
			boost_clr_a: assert property (pair_wr(sel_boost, 2 * g + 1) and !boost_s[g]
				|=> !boost_q[g])
				else $error("boost flag not cleared by paired write");
			boost_hold_a: assert property (wr_en && sel_boost && boost_q[g]
				&& (wdat[2 * g + 1] != wdat[2 * g]) |=> boost_q[g])
				else $error("boost flag lost on unpaired write");
		end
		for (g = 0; g < LED_FLAGS; g++) begin : g_led_chk
			led_set_a: assert property (led_set[g] |=> led_q[g])
				else $error("led flag not latched");
			led_clr_a: assert property (pair_wr(sel_led, LED_COMB_BIT + 2 * g) and !led_set[g]
				|=> !led_q[g])
				else $error("led flag not cleared by paired write");
		end
	endgenerate

	detail_clr_a: assert property (pair_wr(sel_led, LED_COMB_BIT) and !short_s && !open_s
		|=> !short_q && !open_q)
		else $error("detail flags survive combined clear");

	led_read_a: assert property (led_rd_seq |-> prdata[GROUND_BIT] == $past(gnd_s)
		&& prdata[CHANS-1:0] == $past(chan_s))
		else $error("live led bits read wrong");

	reserved_bit_a: assert property (wr_en && sel_led && pstrb[1]
		|=> led_rd[LED_RESERVED_BIT] == $past(pwdata[LED_RESERVED_BIT]))
		else $error("reserved bit storage wrong");

	pin_follow_a: assert property (boost_q[BOOST_FLAGS-1] || led_q[0] |=> fault_pin)
		else $error("fault pin not raised");

	pin_release_a: assert property ((pin_src == '0) [*2] |-> !fault_pin)
		else $error("fault pin not released");
endmodule

// ==== fsc_pkg.sv ====
package fsc_pkg;

	// ==========================================================
	// Register map; byte address is four times the word index
	localparam logic [7:0] BOOST_IDX      = 8'h10;
	localparam logic [7:0] LED_IDX        = 8'h12;
	localparam logic [7:0] BOOST_ADDR     = {BOOST_IDX[5:0], 2'b00};
	localparam logic [7:0] LED_ADDR       = {LED_IDX[5:0], 2'b00};
	localparam logic [7:0] IRQ_STAT_ADDR  = 8'h60;
	localparam logic [7:0] IRQ_MASK_ADDR  = 8'h64;
	localparam int         MIN_ADDR_W     = 7;

	// ==========================================================
	// Field layout
	localparam int BOOST_FLAGS       = 8;
	localparam int LED_FLAGS         = 3;
	localparam int CHANS             = 6;
	localparam int REG_W             = 16;
	localparam int OVERTEMP_FLAG_BIT = 15;
	localparam int OVERTEMP_CLR_BIT  = 14;
	localparam int LED_RESERVED_BIT  = 15;
	localparam int LED_COMB_BIT      = 10;
	localparam int GROUND_BIT        = 8;
	localparam int SHORT_BIT         = 7;
	localparam int OPEN_BIT          = 6;
	localparam int LED_CTL_BITS      = 4;
	localparam int DETAIL_FLAGS      = 2;

	// ==========================================================
	// Interrupt layout and reset values
	localparam int                      IRQ_BITS       = 2;
	localparam int                      IRQ_BOOST_BIT  = 0;
	localparam int                      IRQ_LED_BIT    = 1;
	localparam logic [IRQ_BITS-1:0]     IRQ_MASK_RESET = 2'h0;
	localparam logic [REG_W-1:0]        REG_RESET      = 16'h0000;

endpackage

// ==== fsc_sync.sv ====
module fsc_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	// ==========================================================
	// Two-stage synchroniser; first stage feeds only the second
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	generate
		if (W < 1) begin : g_chk
			$error("fsc_sync width must be at least one");
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule

// ==== fsc_flags.sv ====
module fsc_flags #(
	parameter int N = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	output logic      [N-1:0] q
);
	// ==========================================================
	// Sticky flags; a set in the clearing cycle wins
	logic [N-1:0] q_reg;

	generate
		if (N < 1) begin : g_chk
			$error("fsc_flags needs at least one flag");
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			q_reg <= '0;
		end else begin
			q_reg <= set | (q_reg & ~clr);
		end
	end

	assign q = q_reg;
endmodule

// ==== fsc_host.sv ====
module fsc_host (
	input  wire logic        ref_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle bus at time zero
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		pstrb <= 4'h0;
	end

	// ==========================================================
	// One APB transfer; the wait is bounded by the bench timeout
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wrs(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, {16'h0000, d}, s, r, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wrs(a, d, 4'hF);
	endtask

	// Status and clear bits go out in a single write
	task automatic pair_clear(input logic [7:0] a, input logic [15:0] pair);
		wrs(a, pair, 4'hF);
	endtask
endmodule

// ==== fsc_bank_tb_top.sv ====
module fsc_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fsc_pkg::*;

	typedef struct packed {
		logic [11:0] src;
		logic [7:0]  addr;
		logic [15:0] seen;
		logic [15:0] clr;
		logic        pin;
	} fsc_row_t;

	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, fault_pin, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [3:0]  pstrb;
	logic [11:0] src = 12'h000;
	logic        gnd = 1'b0;
	logic [5:0]  chan = 6'h00;
	logic        err;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// ==========================================================
	// Fault sources: latched ones first, live ones in hand tests
	fsc_row_t rows [12] = '{
		'{12'h080, BOOST_ADDR, 16'h8000, 16'h4000, 1'b1},
		'{12'h040, BOOST_ADDR, 16'h2000, 16'h1000, 1'b1},
		'{12'h020, BOOST_ADDR, 16'h0800, 16'h0400, 1'b1},
		'{12'h010, BOOST_ADDR, 16'h0200, 16'h0100, 1'b1},
		'{12'h008, BOOST_ADDR, 16'h0080, 16'h0040, 1'b1},
		'{12'h004, BOOST_ADDR, 16'h0020, 16'h0010, 1'b1},
		'{12'h002, BOOST_ADDR, 16'h0008, 16'h0004, 1'b1},
		'{12'h001, BOOST_ADDR, 16'h0002, 16'h0001, 1'b0},
		'{12'h100, LED_ADDR, 16'h4000, 16'h2000, 1'b1},
		'{12'h200, LED_ADDR, 16'h1000, 16'h0800, 1'b1},
		'{12'h400, LED_ADDR, 16'h0440, 16'h0200, 1'b1},
		'{12'h800, LED_ADDR, 16'h0480, 16'h0200, 1'b1}
	};

	always #12.5 ref_clk = ~ref_clk;

	fsc_host fsc_host_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	fsc_bank #(.ADDR_W(8)) fsc_bank_inst (.ref_clk(ref_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .boost_fault_in(src[7:0]), .bus_timeout_in(src[8]),
		.bad_string_in(src[9]), .ground_short_in(gnd), .internal_short_in(src[11]),
		.open_string_in(src[10]), .chan_fault_in(chan), .fault_pin(fault_pin), .irq(irq));

	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		fsc_host_inst.xfer(1'b0, a, 32'h0, 4'h0, rv, err);
		chk(rv, {16'h0000, exp}, "read data");
	endtask

	task automatic stop_test();
		$display("mismatches %0d compares %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Ceiling well above the roughly five hundred cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			bad_count++;
			stop_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		rd_chk(BOOST_ADDR, REG_RESET);
		rd_chk(LED_ADDR, REG_RESET);
		rd_chk(IRQ_MASK_ADDR, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			@(posedge ref_clk);
			src <= rows[i].src;
			repeat (5) @(posedge ref_clk);
			src <= 12'h000;
			repeat (3) @(posedge ref_clk);
			rd_chk(rows[i].addr, rows[i].seen);
			chk(32'(fault_pin), 32'(rows[i].pin), "pin while latched");
			fsc_host_inst.wr(rows[i].addr, rows[i].seen);
			rd_chk(rows[i].addr, rows[i].seen);
			fsc_host_inst.wr(rows[i].addr, rows[i].clr);
			rd_chk(rows[i].addr, rows[i].seen | rows[i].clr);
			chk(32'(fault_pin), 32'(rows[i].pin), "pin after half write");
			fsc_host_inst.pair_clear(rows[i].addr, rows[i].seen | rows[i].clr);
			rd_chk(rows[i].addr, rows[i].clr);
			chk(32'(fault_pin), 32'h0, "pin after pair clear");
			fsc_host_inst.wr(rows[i].addr, 16'h0000);
		end
		// Events stay sticky until written one; mask gates irq
		rd_chk(IRQ_STAT_ADDR, 16'h0003);
		fsc_host_inst.wr(IRQ_MASK_ADDR, 16'h0001);
		@(negedge ref_clk);
		chk(32'(irq), 32'h1, "irq unmasked");
		fsc_host_inst.wr(IRQ_STAT_ADDR, 16'h0001);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0, "irq after clear");
		rd_chk(IRQ_STAT_ADDR, 16'h0002);
		fsc_host_inst.wr(IRQ_MASK_ADDR, 16'h0000);
		// Ground short is a live level; combined flag stays latched
		@(posedge ref_clk);
		gnd <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd_chk(LED_ADDR, 16'h0500);
		gnd <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd_chk(LED_ADDR, 16'h0400);
		fsc_host_inst.pair_clear(LED_ADDR, 16'h0600);
		rd_chk(LED_ADDR, 16'h0200);
		chan <= 6'h25;
		repeat (4) @(posedge ref_clk);
		rd_chk(LED_ADDR, 16'h0225);
		chan <= 6'h1A;
		repeat (3) @(posedge ref_clk);
		rd_chk(LED_ADDR, 16'h021A);
		chan <= 6'h00;
		// Read-only bits ignore writes, reserved bit stores
		fsc_host_inst.wr(LED_ADDR, 16'h81FF);
		repeat (3) @(posedge ref_clk);
		rd_chk(LED_ADDR, 16'h8000);
		fsc_host_inst.xfer(1'b0, 8'h44, 32'h0, 4'h0, rv, err);
		chk({rv[31:1], err}, 32'h1, "unmapped read");
		chk(32'(pready), 32'h1, "ready level");
		fsc_host_inst.xfer(1'b1, 8'h44, 32'h0, 4'hF, rv, err);
		chk(32'(err), 32'h1, "unmapped write");
		// Pair in a disabled lane must not clear
		src <= 12'h080;
		repeat (5) @(posedge ref_clk);
		src <= 12'h000;
		fsc_host_inst.wrs(BOOST_ADDR, 16'hC000, 4'h1);
		rd_chk(BOOST_ADDR, 16'h8000);
		// Second reset in mid-run with a flag latched
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		chk(32'(fault_pin), 32'h0, "pin after reset");
		rd_chk(BOOST_ADDR, 16'h0000);
		rd_chk(LED_ADDR, 16'h0000);
		stop_test();
	end
endmodule
